// File: hw/tps_sequencer.sv
// pen task sequencer: task selection, operation state machine and settings port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module tps_sequencer
    import tps_pkg::*;
#(
    parameter logic [HB_W-1:0] HB_HALF = HB_W'(HB_HALF_CYC),
    parameter logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(IDLE_CYC),
    parameter logic [ADC_W-1:0] ADC_INTERVAL = ADC_W'(ADC_CYC)
) (
    input wire logic core_clk,
    input wire logic rst,
    // straps and charger flag
    input wire logic mode_strap_a,
    input wire logic mode_strap_b,
    input wire logic adapter_present_flag,
    // attach commands and data decoded from the serial link
    input wire logic attach_valid,
    input wire logic attach_viewer,
    input wire tps_byte_t link_rx,
    // sensor configuration writer
    input wire logic ee_done,
    input wire logic ee_ok,
    // optical code sensor decoder
    input wire tps_code_t sticker,
    // keys, battery and player
    input wire logic key_up,
    input wire logic key_down,
    input wire logic adc_valid,
    input wire logic [11:0] adc_mv,
    input wire logic play_done,
    // settings port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // outputs
    output tps_task_t task_sel,
    output tps_op_t op_state,
    output logic green_led,
    output logic ee_start,
    output logic adc_start,
    output tps_code_t play,
    output tps_code_t code_fwd,
    output tps_byte_t sd_wr,
    output logic [3:0] volume,
    output logic periph_en,
    output logic halt_req,
    output logic wdt_run
);

    tps_state_t s_q;
    tps_state_t s_d;

    // one saturating volume step, used by keys in both directions
    function automatic logic [3:0] vol_step(input logic [3:0] v, input logic up);
        logic [3:0] r;
        r = v;
        if (up && v != VOL_MAX) begin
            r = v + 4'h1;
        end else if (!up && v != VOL_MIN) begin
            r = v - 4'h1;
        end
        return r;
    endfunction : vol_step

    logic up_edge;
    logic dn_edge;
    logic activity;
    tps_status_t status;

    // keys are levels; only the press edge counts as a step
    assign up_edge = key_up && !s_q.up_prev;
    assign dn_edge = key_down && !s_q.dn_prev;
    assign activity = up_edge || dn_edge || sticker.valid;

    assign status.pad = 2'b00;
    assign status.led = s_q.green_led;
    assign status.op = s_q.op;
    assign status.task_sel = s_q.task_sel;

    // next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.ee_start = 1'b0;
        s_d.adc_start = 1'b0;
        s_d.play.valid = 1'b0;
        s_d.fwd.valid = 1'b0;
        s_d.sd_wr.valid = 1'b0;
        s_d.rdata = 8'h00;
        s_d.up_prev = key_up;
        s_d.dn_prev = key_down;

        case (s_q.task_sel)
            T_SAMPLE: begin
                // single look at the straps, taken in the first clock after reset
                if (mode_strap_a && mode_strap_b) begin
                    s_d.task_sel = T_EEPROM;
                end else if (!mode_strap_a && !mode_strap_b) begin
                    if (adapter_present_flag) begin
                        s_d.task_sel = T_OPER;
                        s_d.op = O_NORMAL;
                        s_d.periph_en = 1'b1;
                    end else begin
                        s_d.task_sel = T_ATTACH;
                    end
                end else begin
                    s_d.task_sel = T_HOLD;
                end
            end
            T_HOLD: begin
                // straps disagree: no task until the next reset
                s_d.task_sel = T_HOLD;
            end
            T_EEPROM: begin
                if (!s_q.ee_started) begin
                    s_d.ee_start = 1'b1;
                    s_d.ee_started = 1'b1;
                end else if (ee_done && ee_ok) begin
                    s_d.ee_ok = 1'b1;
                    s_d.green_led = 1'b1;
                end
            end
            T_ATTACH: begin
                // the command from the loader or the viewer decides the task
                if (attach_valid) begin
                    if (attach_viewer) begin
                        s_d.task_sel = T_VIEW;
                    end else begin
                        s_d.task_sel = T_CARD;
                    end
                end
            end
            T_CARD: begin
                // link bytes go on to the card writer one cycle later
                s_d.sd_wr = link_rx;
            end
            T_VIEW: begin
                if (sticker.valid) begin
                    s_d.fwd = sticker;
                end
            end
            T_OPER: begin
                case (s_q.op)
                    O_NORMAL: begin
                        // heartbeat: toggle every half period
                        if (s_q.hb_cnt == HB_HALF - HB_W'(1)) begin
                            s_d.hb_cnt = '0;
                            s_d.green_led = !s_q.green_led;
                        end else begin
                            s_d.hb_cnt = s_q.hb_cnt + HB_W'(1);
                        end
                        if (sticker.valid) begin
                            s_d.play = sticker;
                        end
                        if (up_edge) begin
                            s_d.volume = vol_step(s_q.volume, 1'b1);
                        end else if (dn_edge) begin
                            s_d.volume = vol_step(s_q.volume, 1'b0);
                        end
                        // regular battery sampling
                        if (s_q.adc_cnt == ADC_INTERVAL - ADC_W'(1)) begin
                            s_d.adc_cnt = '0;
                            s_d.adc_start = 1'b1;
                        end else begin
                            s_d.adc_cnt = s_q.adc_cnt + ADC_W'(1);
                        end
                        // idle timer restarts on any sticker or key
                        if (activity) begin
                            s_d.idle_cnt = '0;
                        end else begin
                            s_d.idle_cnt = s_q.idle_cnt + IDLE_W'(1);
                        end
                        // battery check wins over the idle timeout
                        if (adc_valid && adc_mv < LOW_BATT_MV) begin
                            s_d.op = O_LOWPWR;
                            s_d.play.valid = 1'b1;
                            s_d.play.code = WARN_CODE;
                            s_d.green_led = 1'b0;
                        end else if (!activity &&
                                     s_q.idle_cnt == IDLE_LIMIT - IDLE_W'(1)) begin
                            s_d.op = O_SHUTDN;
                            s_d.periph_en = 1'b0;
                            s_d.green_led = 1'b0;
                        end
                    end
                    O_LOWPWR: begin
                        // stickers and keys are ignored while the warning plays
                        if (play_done) begin
                            s_d.op = O_SHUTDN;
                            s_d.periph_en = 1'b0;
                        end
                    end
                    O_SHUTDN: begin
                        // peripherals already off; halt one cycle later
                        s_d.periph_en = 1'b0;
                        s_d.halt_req = 1'b1;
                    end
                    default: begin
                        s_d.op = O_SHUTDN;
                    end
                endcase
            end
            default: begin
                s_d.task_sel = T_HOLD;
            end
        endcase

        // settings port: software may set the volume directly
        if (reg_we && reg_addr == OFS_VOLUME) begin
            s_d.volume = reg_wdata[3:0];
        end

        // read data registered, present only in the cycle after the strobe
        if (reg_re) begin
            if (reg_addr == OFS_WDT_SET) begin
                s_d.rdata = WDT_SET_VAL;
            end else if (reg_addr == OFS_VDET_SET) begin
                s_d.rdata = VDET_SET_VAL;
            end else if (reg_addr == OFS_OSC_SET) begin
                s_d.rdata = OSC_SET_VAL;
            end else if (reg_addr == OFS_DBG_SET) begin
                s_d.rdata = DBG_SET_VAL;
            end else if (reg_addr == OFS_VOLUME) begin
                s_d.rdata = {4'h0, s_q.volume};
            end else if (reg_addr == OFS_STATUS) begin
                s_d.rdata = status;
            end else begin
                s_d.rdata = 8'h00;
            end
        end
    end

    // the only state register; shut-down is left only through rst
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.task_sel <= T_SAMPLE;
            s_q.op <= O_NORMAL;
            s_q.ee_started <= 1'b0;
            s_q.ee_ok <= 1'b0;
            s_q.green_led <= 1'b0;
            s_q.hb_cnt <= '0;
            s_q.idle_cnt <= '0;
            s_q.adc_cnt <= '0;
            s_q.volume <= VOL_RST;
            s_q.up_prev <= 1'b0;
            s_q.dn_prev <= 1'b0;
            s_q.ee_start <= 1'b0;
            s_q.adc_start <= 1'b0;
            s_q.play <= '0;
            s_q.fwd <= '0;
            s_q.sd_wr <= '0;
            s_q.periph_en <= 1'b0;
            s_q.halt_req <= 1'b0;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s_q.rdata;
    assign task_sel = s_q.task_sel;
    assign op_state = s_q.op;
    assign green_led = s_q.green_led;
    assign ee_start = s_q.ee_start;
    assign adc_start = s_q.adc_start;
    assign play = s_q.play;
    assign code_fwd = s_q.fwd;
    assign sd_wr = s_q.sd_wr;
    assign volume = s_q.volume;
    assign periph_en = s_q.periph_en;
    assign halt_req = s_q.halt_req;
    // watchdog held stopped from reset on, matching its startup setting
    assign wdt_run = 1'b0;

endmodule : tps_sequencer

// File: hw/tps_pkg.sv
// constants, types and the startup settings map of the pen task sequencer
// Contract
// - both straps high after reset: run the sensor configuration EEPROM write task
// - successful sensor configuration write turns the green LED on steadily
// - straps low, adapter low, loader attach: card loading task, sound data to card
// - straps low, adapter low, viewer attach: code display task, codes sent to host
// - straps low, adapter high: operation task at once, no host command
// - operation task has exactly three states: normal, low-power, shut-down
// - operation task starts in the normal state
// - normal state toggles the green LED with a two second period
// - normal state starts playback of each recognized sticker code; a sticker in a low battery reading cycle is dropped
// - normal state steps speaker volume up or down on the two keys
// - normal state measures battery voltage at regular intervals
// - entering low-power plays the stored low-power warning sound
// - shut-down disables all peripherals then halts with clocks stopped
// - watchdog counter stays stopped from reset; its setting reads 01101110B
// - supply detector in reset mode, rise 3.13 V, fall 3.06 V, setting 00110011B
// - fast oscillator 64 MHz high-speed mode, core clock 32 MHz, setting 11111000B
// - a 15 kHz low-speed internal oscillator is available as clock source
// - battery below 3.7 V: go low-power, then shut-down after the warning
// - three idle minutes in the operation task lead to shut-down
// - attach commands and sound data travel over the serial link via a bridge
package tps_pkg;

    // clock and timing
    localparam longint CLK_KHZ = 100000;
    localparam longint HB_PERIOD_MS = 2000; // full blink period
    localparam longint IDLE_MIN = 3;
    localparam longint ADC_PERIOD_MS = 100;
    localparam longint HB_HALF_CYC = HB_PERIOD_MS * CLK_KHZ / 2;
    localparam longint IDLE_CYC = IDLE_MIN * 60 * 1000 * CLK_KHZ;
    localparam longint ADC_CYC = ADC_PERIOD_MS * CLK_KHZ;
    localparam int HB_W = 27;
    localparam int IDLE_W = 36;
    localparam int ADC_W = 24;

    // startup settings and their offsets
    localparam logic [7:0] OFS_WDT_SET = 8'hC0;
    localparam logic [7:0] OFS_VDET_SET = 8'hC1;
    localparam logic [7:0] OFS_OSC_SET = 8'hC2;
    localparam logic [7:0] OFS_DBG_SET = 8'hC3;
    localparam logic [7:0] OFS_VOLUME = 8'hC4;
    localparam logic [7:0] OFS_STATUS = 8'hC5;
    localparam logic [7:0] WDT_SET_VAL = 8'h6E;
    localparam logic [7:0] VDET_SET_VAL = 8'h33;
    localparam logic [7:0] OSC_SET_VAL = 8'hF8;
    localparam logic [7:0] DBG_SET_VAL = 8'h84;
    localparam int VDET_RISE_MV = 3130;
    localparam int VDET_FALL_MV = 3060;
    localparam int FAST_OSC_MHZ = 64;
    localparam int CORE_CLK_MHZ = 32;
    localparam int LOW_OSC_KHZ = 15;

    // volume and battery
    localparam logic [3:0] VOL_RST = 4'h8;
    localparam logic [3:0] VOL_MAX = 4'hF;
    localparam logic [3:0] VOL_MIN = 4'h0;
    localparam logic [11:0] LOW_BATT_MV = 12'hE74; // 3700 mV
    localparam logic [15:0] WARN_CODE = 16'h0000;

    typedef enum logic [2:0] {
        T_SAMPLE, T_HOLD, T_EEPROM, T_ATTACH, T_CARD, T_VIEW, T_OPER
    } tps_task_t;

    typedef enum logic [1:0] {O_NORMAL, O_LOWPWR, O_SHUTDN} tps_op_t;

    typedef struct packed {
        logic [1:0] pad;
        logic led;
        tps_op_t op;
        tps_task_t task_sel;
    } tps_status_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tps_byte_t;

    typedef struct packed {
        logic valid;
        logic [15:0] code;
    } tps_code_t;

    typedef struct packed {
        tps_task_t task_sel;
        tps_op_t op;
        logic ee_started;
        logic ee_ok;
        logic green_led;
        logic [HB_W-1:0] hb_cnt;
        logic [IDLE_W-1:0] idle_cnt;
        logic [ADC_W-1:0] adc_cnt;
        logic [3:0] volume;
        logic up_prev;
        logic dn_prev;
        logic ee_start;
        logic adc_start;
        tps_code_t play;
        tps_code_t fwd;
        tps_byte_t sd_wr;
        logic periph_en;
        logic halt_req;
        logic [7:0] rdata;
    } tps_state_t;

endpackage : tps_pkg

// File: sim/tps_seq_props.sv
// concurrent checks on the ports of the pen task sequencer
`timescale 1ns/1ps
module tps_seq_props
    import tps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire tps_task_t task_sel,
    input wire tps_op_t op_state,
    input wire logic green_led,
    input wire logic ee_start,
    input wire logic ee_done,
    input wire logic ee_ok,
    input wire tps_code_t sticker,
    input wire tps_code_t play,
    input wire tps_code_t code_fwd,
    input wire tps_byte_t link_rx,
    input wire tps_byte_t sd_wr,
    input wire logic adc_valid,
    input wire logic [11:0] adc_mv,
    input wire logic periph_en,
    input wire logic halt_req,
    input wire logic wdt_run,
    input wire logic reg_re,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata
);
    logic in_norm;
    logic low_in;
    // low battery wins over a sticker in the same cycle, so plays are judged without it
    assign in_norm = task_sel == T_OPER && op_state == O_NORMAL;
    assign low_in = adc_valid && adc_mv < LOW_BATT_MV;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ee_led_on: assert property (task_sel == T_EEPROM && ee_done && ee_ok |=> green_led)
        else $error("led not on after config write");
    a_play_sticker: assert property (in_norm && sticker.valid && !low_in |=> play.valid && play.code == $past(sticker.code))
        else $error("sticker not played");
    a_fwd_code: assert property (task_sel == T_VIEW && sticker.valid |=> code_fwd.valid && code_fwd.code == $past(sticker.code))
        else $error("code not forwarded");
    a_sd_copy: assert property (task_sel == T_CARD && link_rx.valid |=> sd_wr.valid && sd_wr.data == $past(link_rx.data))
        else $error("link byte not written to card");
    a_low_warn: assert property (in_norm && low_in |=> op_state == O_LOWPWR && play.valid && play.code == WARN_CODE)
        else $error("low battery not handled");
    a_shut_halt: assert property (op_state == O_SHUTDN |-> !periph_en ##1 halt_req)
        else $error("shut-down without halt");
    a_shut_stays: assert property (op_state == O_SHUTDN |=> op_state == O_SHUTDN)
        else $error("left shut-down without reset");
    a_oper_start: assert property (task_sel == T_OPER && $past(task_sel) != T_OPER |-> op_state == O_NORMAL)
        else $error("operation task not started normal");
    a_task_fixed: assert property (task_sel != T_SAMPLE && task_sel != T_ATTACH |=> $stable(task_sel))
        else $error("task changed after selection");
    a_ee_kick: assert property ($rose(task_sel == T_EEPROM) |=> ee_start)
        else $error("config write not started");
    a_wdt_off: assert property (!wdt_run)
        else $error("watchdog running");
    a_rd_osc: assert property (reg_re && reg_addr == OFS_OSC_SET |=> reg_rdata == OSC_SET_VAL)
        else $error("oscillator setting wrong");
endmodule : tps_seq_props

bind tps_sequencer tps_seq_props chk_u (.*);

// File: sim/tps_partner.sv
// far side model: sensor configuration writer and sound player
`timescale 1ns/1ps
module tps_partner
    import tps_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic ee_start,
    input wire tps_code_t play,
    output logic ee_done,
    output logic ee_ok,
    output logic play_done
);
    logic [3:0] ee_cnt_q;
    logic [3:0] pl_cnt_q;
    // each request starts a short or long countdown that ends in one answer pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ee_cnt_q <= 4'h0;
            pl_cnt_q <= 4'h0;
            ee_done <= 1'b0;
            ee_ok <= 1'b0;
            play_done <= 1'b0;
        end else begin
            ee_done <= ee_cnt_q == 4'h1;
            // outside the answer the status flips so it cannot pass as valid by luck
            ee_ok <= (ee_cnt_q == 4'h1) ? 1'b1 : ~ee_ok;
            play_done <= pl_cnt_q == 4'h1;
            if (ee_start) ee_cnt_q <= slow ? 4'hC : 4'h2;
            else if (ee_cnt_q != 4'h0) ee_cnt_q <= ee_cnt_q - 4'h1;
            if (play.valid) pl_cnt_q <= slow ? 4'hA : 4'h2;
            else if (pl_cnt_q != 4'h0) pl_cnt_q <= pl_cnt_q - 4'h1;
        end
    end
endmodule : tps_partner

// File: sim/tps_sequencer_tb.sv
// self-checking bench of the pen task sequencer
`timescale 1ns/1ps
module tps_sequencer_tb
    import tps_pkg::*;
;
    logic core_clk = 1'b0, rst = 1'b1, slow = 1'b1;
    logic mode_strap_a = 1'b0, mode_strap_b = 1'b0, adapter_present_flag = 1'b0;
    logic attach_valid = 1'b0, attach_viewer = 1'b0, key_up = 1'b0, key_down = 1'b0;
    logic adc_valid = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [11:0] adc_mv = 12'hFFF;
    tps_byte_t link_rx = '0;
    tps_code_t sticker = '0;
    logic ee_done, ee_ok, play_done, green_led, ee_start, adc_start, periph_en, halt_req, wdt_run;
    logic [7:0] reg_rdata;
    logic [3:0] volume, exp_vol;
    tps_task_t task_sel;
    tps_op_t op_state;
    tps_code_t play, code_fwd;
    tps_byte_t sd_wr;
    logic [31:0] seed = 32'h9E98, r;
    logic led_l;
    int failures = 0, n_compared = 0, n;
    logic [7:0] set_v [4] = '{WDT_SET_VAL, VDET_SET_VAL, OSC_SET_VAL, DBG_SET_VAL};

    // short counts keep the run brief; expectations below follow these values
    tps_sequencer #(.HB_HALF(27'h8), .IDLE_LIMIT(36'hC8), .ADC_INTERVAL(24'h10)) dut_u (.*);
    tps_partner peer_u (.*);

    initial forever #5 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // expected volume after one press, saturating at both ends
    function automatic logic [3:0] vstep(input logic [3:0] v, input logic up);
        if (up) return (v == VOL_MAX) ? v : v + 4'h1;
        return (v == VOL_MIN) ? v : v - 4'h1;
    endfunction : vstep
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc();
        @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic do_reset(input logic a, input logic b, input logic p);
        @(posedge core_clk);
        rst <= 1'b1;
        mode_strap_a <= a;
        mode_strap_b <= b;
        adapter_present_flag <= p;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : do_reset
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe, so they are looked at there
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        chk("reg_rdata", 17'(e), 17'(reg_rdata));
    endtask : reg_rd
    task automatic press(input logic up);
        @(posedge core_clk);
        key_up <= up;
        key_down <= !up;
        @(posedge core_clk);
        key_up <= 1'b0;
        key_down <= 1'b0;
        #1;
    endtask : press
    task automatic stick(input logic [15:0] c);
        @(posedge core_clk);
        sticker <= {1'b1, c};
        @(posedge core_clk);
        sticker <= '0;
        #1;
    endtask : stick
    task automatic adcv(input logic [11:0] mv);
        @(posedge core_clk);
        adc_valid <= 1'b1;
        adc_mv <= mv;
        @(posedge core_clk);
        adc_valid <= 1'b0;
        #1;
    endtask : adcv
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        do_reset(1'b1, 1'b1, 1'b0);
        chk("task", 17'(T_EEPROM), 17'(task_sel));
        for (n = 0; n < 40 && green_led !== 1'b1; n++) cyc();
        chk("green_led", 17'h1, 17'(green_led));
        do_reset(1'b0, 1'b1, 1'b0);
        chk("task", 17'(T_HOLD), 17'(task_sel));
        // both attach kinds, each followed at once by a link byte and a sticker
        for (int v = 0; v < 2; v++) begin
            do_reset(1'b0, 1'b0, 1'b0);
            chk("task", 17'(T_ATTACH), 17'(task_sel));
            @(posedge core_clk);
            attach_valid <= 1'b1;
            attach_viewer <= v[0];
            @(posedge core_clk);
            attach_valid <= 1'b0;
            r = rnd();
            link_rx <= {1'b1, r[7:0]};
            sticker <= {1'b1, r[23:8]};
            @(posedge core_clk);
            link_rx <= '0;
            sticker <= '0;
            #1;
            chk("task", 17'(v ? T_VIEW : T_CARD), 17'(task_sel));
            if (v == 0) chk("sd_wr", 17'({1'b1, r[7:0]}), 17'(sd_wr));
            else chk("code_fwd", {1'b1, r[23:8]}, 17'(code_fwd));
        end
        slow <= 1'b0;
        do_reset(1'b0, 1'b0, 1'b1);
        chk("task", 17'(T_OPER), 17'(task_sel));
        chk("op", 17'(O_NORMAL), 17'(op_state));
        led_l = green_led;
        for (n = 0; n < 40 && green_led === led_l; n++) cyc();
        led_l = green_led;
        for (n = 0; n < 40 && (n == 0 || green_led === led_l); n++) cyc();
        chk("hb_half", 17'h8, 17'(n));
        n = 0;
        repeat (64) begin
            cyc();
            if (adc_start === 1'b1) n++;
        end
        chk("adc_starts", 17'h4, 17'(n));
        for (int k = 0; k < 4; k++) reg_rd(OFS_WDT_SET + 8'(k), set_v[k]);
        reg_rd(8'h10, 8'h00);
        reg_wr(OFS_WDT_SET, 8'h00);
        reg_rd(OFS_WDT_SET, WDT_SET_VAL);
        reg_wr(OFS_VOLUME, 8'h0F);
        reg_rd(OFS_VOLUME, 8'h0F);
        exp_vol = 4'hF;
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            if (k == 6) reg_wr(OFS_VOLUME, 8'h00);
            if (k == 6) exp_vol = 4'h0;
            press(k == 0 || k == 6 ? k == 0 : r[0]);
            exp_vol = vstep(exp_vol, k == 0 || k == 6 ? k == 0 : r[0]);
            chk("volume", 17'(exp_vol), 17'(volume));
        end
        stick(r[31:16]);
        chk("play", {1'b1, r[31:16]}, 17'(play));
        adcv(LOW_BATT_MV);
        chk("op", 17'(O_NORMAL), 17'(op_state));
        adcv(LOW_BATT_MV - 12'h1);
        chk("op", 17'(O_LOWPWR), 17'(op_state));
        chk("play", {1'b1, WARN_CODE}, 17'(play));
        for (n = 0; n < 40 && op_state !== O_SHUTDN; n++) cyc();
        chk("periph_en", 17'h0, 17'(periph_en));
        cyc();
        chk("halt_req", 17'h1, 17'(halt_req));
        stick(16'h6221);
        press(1'b1);
        chk("op", 17'(O_SHUTDN), 17'(op_state));
        // status word: led off, shut-down, operation task
        reg_rd(OFS_STATUS, {2'b00, 1'b0, 2'(O_SHUTDN), 3'(T_OPER)});
        do_reset(1'b0, 1'b0, 1'b1);
        for (n = 0; n < 400 && op_state !== O_SHUTDN; n++) cyc();
        chk("idle_window", 17'h1, 17'(n >= 190 && n <= 205));
        test_done();
    end
endmodule : tps_sequencer_tb
